// File: core/cache_maint_map.vh
// Constants for the cache maintenance error policy block
`ifndef CACHE_MAINT_MAP_VH
`define CACHE_MAINT_MAP_VH

// Ways per cache set
`define CM_WAYS            4
`define CM_WAY_BITS        2

// Error action field values
`define CM_EA_OFF          2'h0
`define CM_EA_CORRECT      2'h1

// Operation codes
`define CM_OP_NONE         4'h0
`define CM_OP_REG_INV      4'h1
`define CM_OP_REG_FLUSH    4'h2
`define CM_OP_REG_FLINV    4'h3
`define CM_OP_TOUCH        4'h4
`define CM_OP_IBLK_INV     4'h5
`define CM_OP_DBLK_INV     4'h6
`define CM_OP_DBLK_STORE   4'h7
`define CM_OP_DBLK_FLUSH   4'h8
`define CM_OP_DBLK_ZERO    4'h9
`define CM_OP_LOCK_SET     4'ha
`define CM_OP_LOCK_CLR     4'hb

`endif

// File: core/way_error_class.v
// Per-way classification of tag, lock and dirty state for the policy
`timescale 1ns/1ps
`default_nettype none

module way_error_class (
	// Raw way state
	input  wire       valid,
	input  wire       tag_match,
	input  wire       tag_err,
	input  wire       tag_unc,
	input  wire       locked,
	input  wire       lock_err,
	input  wire       dirty,
	input  wire       dirty_err,
	// Classification
	output wire       clean_hit,
	output wire       err_hit,
	output wire       unc_line,
	output wire       is_dirty,
	output wire       is_locked,
	output wire       clean_unlocked_unc
);

	// An errored tag cannot be trusted as a hit; only a clean tag counts
	assign clean_hit          = valid & tag_match & ~tag_err;
	assign err_hit            = valid & tag_match & tag_err;
	assign unc_line           = valid & tag_unc;
	assign is_dirty           = dirty | dirty_err;
	assign is_locked          = locked | lock_err;
	assign clean_unlocked_unc = unc_line & ~is_dirty & ~is_locked;

endmodule

`default_nettype wire

// File: core/cache_maint_error_policy.v
// Maintenance error policy for first-level instruction and data caches
`timescale 1ns/1ps
`default_nettype none
`include "cache_maint_map.vh"

module cache_maint_error_policy (
	// Clock and reset
	input  wire       clk_sys,
	input  wire       reset,
	// Cache control bits
	input  wire       dcache_error_check_enable,
	input  wire       icache_error_check_enable,
	input  wire [1:0] dcache_error_action,
	input  wire [1:0] icache_error_action,
	// Request from the core pipelines
	input  wire       req_valid,
	input  wire [3:0] req_op,
	input  wire       req_icache,
	input  wire       req_cacheable,
	input  wire [1:0] selected_way,
	// Lookup state per way, bit index is the way
	input  wire [3:0] way_valid,
	input  wire [3:0] way_tag_match,
	input  wire [3:0] way_tag_err,
	input  wire [3:0] way_tag_unc,
	input  wire [3:0] way_locked,
	input  wire [3:0] way_lock_err,
	input  wire [3:0] way_dirty,
	input  wire [3:0] way_dirty_err,
	input  wire [3:0] way_data_err,
	// Decided actions, registered
	output reg        act_valid,
	output reg  [3:0] act_op,
	output reg  [3:0] act_invalidate,
	output reg  [3:0] act_writeback,
	output reg  [3:0] act_clear_lock,
	output reg  [3:0] act_set_lock,
	output reg  [3:0] act_zero,
	output reg        act_correct_cycle,
	output reg        act_nop,
	// Machine check event
	output reg        mchk_pulse,
	output reg        mchk_push_parity,
	output reg  [3:0] mchk_op
);

	////////////////////////////////////////////////////////////////////////
	wire [3:0] clean_hit;
	wire [3:0] err_hit;
	wire [3:0] unc_line;
	wire [3:0] is_dirty;
	wire [3:0] is_locked;
	wire [3:0] cu_unc;

	genvar g;
	generate
		for (g = 0; g < `CM_WAYS; g = g + 1) begin : g_way
			way_error_class u_class (
				.valid              (way_valid[g]),
				.tag_match          (way_tag_match[g]),
				.tag_err            (way_tag_err[g]),
				.tag_unc            (way_tag_unc[g]),
				.locked             (way_locked[g]),
				.lock_err           (way_lock_err[g]),
				.dirty              (way_dirty[g]),
				.dirty_err          (way_dirty_err[g]),
				.clean_hit          (clean_hit[g]),
				.err_hit            (err_hit[g]),
				.unc_line           (unc_line[g]),
				.is_dirty           (is_dirty[g]),
				.is_locked          (is_locked[g]),
				.clean_unlocked_unc (cu_unc[g])
			);
		end
	endgenerate

	// One-hot of the way named by the register operation
	function [3:0] way_onehot;
		input [1:0] w;
		begin
			way_onehot = 4'h1 << w;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Enable and action follow the cache that the request targets
	wire       chk_en   = req_icache ? icache_error_check_enable
	                                 : dcache_error_check_enable;
	wire [1:0] ea       = req_icache ? icache_error_action : dcache_error_action;
	wire       ea_on    = (ea == `CM_EA_CORRECT);
	wire       any_ch   = |clean_hit;
	wire       any_terr = |(way_tag_err & way_valid);
	wire [3:0] sel      = way_onehot(selected_way);
	// Only the selected way is examined by register operations
	wire       s_unc    = |(sel & unc_line);
	wire       s_dirty  = |(sel & is_dirty & way_valid);
	wire       s_derr   = |(sel & way_data_err);
	wire [3:0] unc_dirty = unc_line & is_dirty;
	wire [3:0] unc_lock  = unc_line & is_locked;
	wire [3:0] unc_clean = unc_line & ~is_dirty;

	reg  [3:0] next_inv;
	reg  [3:0] next_wb;
	reg  [3:0] next_clr;
	reg  [3:0] next_set;
	reg  [3:0] next_zero;
	reg        next_corr;
	reg        next_nop;
	reg        next_mchk;
	reg        next_pp;

	always @* begin
		next_inv  = 4'h0;
		next_wb   = 4'h0;
		next_clr  = 4'h0;
		next_set  = 4'h0;
		next_zero = 4'h0;
		next_corr = 1'b0;
		next_nop  = 1'b0;
		next_mchk = 1'b0;
		next_pp   = 1'b0;
		case (req_op)
		`CM_OP_REG_INV: begin
			// Line goes regardless of tag, data or dirty errors
			next_inv = sel;
			next_clr = sel;
		end
		`CM_OP_REG_FLUSH, `CM_OP_REG_FLINV: begin
			if (s_unc && s_dirty) begin
				next_mchk = chk_en;
			end else if (s_unc) begin
				if (req_op == `CM_OP_REG_FLINV) begin
					next_inv = sel;
					next_clr = sel;
				end
			end else begin
				if (s_dirty)
					next_wb = sel;
				next_pp   = chk_en & s_dirty & s_derr;
				next_mchk = next_pp;
				// Push parity keeps the line for a later retry
				if (req_op == `CM_OP_REG_FLINV && !next_pp) begin
					next_inv = sel;
					next_clr = sel;
				end
			end
		end
		`CM_OP_TOUCH: begin
			next_nop = |(unc_line & way_tag_match);
		end
		`CM_OP_IBLK_INV: begin
			// Locked errored hits stay untouched; misses go only when clean, unlocked and uncorrectable under correction
			next_inv  = clean_hit | (err_hit & ~is_locked);
			next_corr = chk_en & ea_on & any_terr;
			// Data errors never matter to an instruction invalidate
			if (next_corr)
				next_inv = next_inv | (cu_unc & ~err_hit);
		end
		`CM_OP_DBLK_INV: begin
			if (any_ch)
				next_inv = clean_hit;
			else
				next_inv = err_hit & ~is_dirty & ~is_locked;
			if (ea_on && chk_en)
				next_inv = next_inv | cu_unc;
		end
		`CM_OP_DBLK_STORE, `CM_OP_DBLK_FLUSH: begin
			if (any_ch) begin
				next_wb = clean_hit & is_dirty;
				if (req_op == `CM_OP_DBLK_FLUSH)
					next_inv = clean_hit;
				next_pp   = chk_en & |(next_wb & way_data_err);
				next_mchk = next_pp;
				// Other bad clean unlocked tags are dropped under 01
				if (ea_on && chk_en)
					next_inv = next_inv | cu_unc;
			end else if (req_cacheable && chk_en) begin
				// Uncached or unchecked misses stay silent
				if (ea_on)
					next_inv = cu_unc;
				if (req_op == `CM_OP_DBLK_STORE)
					next_mchk = |unc_dirty;
				else
					next_mchk = |unc_dirty | |unc_lock;
			end
		end
		`CM_OP_DBLK_ZERO: begin
			if (any_ch) begin
				next_zero = clean_hit;
				if (ea_on && chk_en)
					next_inv = cu_unc;
			end else if (req_cacheable && chk_en) begin
				if (ea_on) begin
					next_inv  = unc_clean;
					next_mchk = |unc_dirty | |(unc_clean & is_locked);
				end else begin
					next_mchk = any_terr | |(way_lock_err & way_valid);
				end
				// A check cancels the whole zeroing
				if (next_mchk)
					next_inv = 4'h0;
			end
		end
		`CM_OP_LOCK_SET, `CM_OP_LOCK_CLR: begin
			if (any_ch) begin
				if (req_op == `CM_OP_LOCK_SET)
					next_set = clean_hit;
				else
					next_clr = clean_hit;
				if (ea_on && chk_en)
					next_inv = cu_unc;
			end else if (req_cacheable && chk_en) begin
				if (req_op == `CM_OP_LOCK_SET) begin
					if (ea_on) begin
						next_inv  = unc_clean;
						next_mchk = |(unc_clean & is_locked) | |unc_dirty;
					end else begin
						next_mchk = any_terr | |(way_lock_err & way_valid);
					end
				end else begin
					if (ea_on) begin
						next_inv  = unc_clean;
						next_mchk = |(unc_clean & is_locked) | |(unc_dirty & is_locked);
					end else begin
						next_mchk = |(way_tag_err & way_valid & is_locked);
					end
				end
			end
		end
		default: begin
			next_nop = 1'b0;
		end
		endcase
		// Disabled checking drops every error report
		if (!chk_en) begin
			next_mchk = 1'b0;
			next_pp   = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Decisions are registered so the array controllers see stable data
	always @(posedge clk_sys) begin
		if (reset) begin
			act_valid         <= 1'b0;
			act_op            <= `CM_OP_NONE;
			act_invalidate    <= 4'h0;
			act_writeback     <= 4'h0;
			act_clear_lock    <= 4'h0;
			act_set_lock      <= 4'h0;
			act_zero          <= 4'h0;
			act_correct_cycle <= 1'b0;
			act_nop           <= 1'b0;
			mchk_pulse        <= 1'b0;
			mchk_push_parity  <= 1'b0;
			mchk_op           <= `CM_OP_NONE;
		end else begin
			act_valid         <= req_valid;
			act_op            <= req_op;
			act_invalidate    <= req_valid ? next_inv : 4'h0;
			act_writeback     <= req_valid ? next_wb : 4'h0;
			act_clear_lock    <= req_valid ? next_clr : 4'h0;
			act_set_lock      <= req_valid ? next_set : 4'h0;
			act_zero          <= req_valid ? next_zero : 4'h0;
			act_correct_cycle <= req_valid & next_corr;
			act_nop           <= req_valid & next_nop;
			mchk_pulse        <= req_valid & next_mchk;
			mchk_push_parity  <= req_valid & next_pp;
			if (req_valid && next_mchk)
				mchk_op <= req_op;
		end
	end

endmodule

`default_nettype wire

// File: verification/cache_maint_error_policy_asserts.sv
// Port checks for the cache maintenance error policy
`timescale 1ns/1ps
`default_nettype none
`include "cache_maint_map.vh"
module cache_maint_error_policy_asserts (
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       reset,
	// Controls and request
	input wire logic       dcache_error_check_enable,
	input wire logic       icache_error_check_enable,
	input wire logic       req_valid,
	input wire logic [3:0] req_op,
	input wire logic       req_icache,
	input wire logic [1:0] selected_way,
	// Decisions
	input wire logic       act_valid,
	input wire logic [3:0] act_op,
	input wire logic [3:0] act_invalidate,
	input wire logic       mchk_pulse,
	input wire logic       mchk_push_parity,
	input wire logic [3:0] mchk_op
);
default clocking @(posedge clk_sys); endclocking
default disable iff (reset);
wire chk_on = req_icache ? icache_error_check_enable : dcache_error_check_enable;
wire reg_op = req_op == `CM_OP_REG_INV || req_op == `CM_OP_REG_FLUSH || req_op == `CM_OP_REG_FLINV;
//////////////////////////////////////////////////
a_answer_next: assert property (req_valid |=> act_valid && act_op == $past(req_op))
	else $error("decision missing one cycle after request");
a_idle_quiet: assert property (!act_valid |-> act_invalidate == 4'h0 && !mchk_pulse)
	else $error("action without a request");
a_check_off: assert property (req_valid && !chk_on |=> !mchk_pulse && !mchk_push_parity)
	else $error("machine check while checking disabled");
a_reg_one_way: assert property (req_valid && reg_op |=>
	(act_invalidate & ~(4'h1 << $past(selected_way))) == 4'h0)
	else $error("register op touched an unselected way");
a_touch_quiet: assert property (req_valid && req_op == `CM_OP_TOUCH |=>
	!mchk_pulse && act_invalidate == 4'h0)
	else $error("touch reported or invalidated");
a_blk_silent: assert property (req_valid && (req_op == `CM_OP_IBLK_INV ||
	req_op == `CM_OP_DBLK_INV || req_op == `CM_OP_REG_INV) |=> !mchk_pulse)
	else $error("invalidate raised a machine check");
a_push_pulse: assert property (mchk_push_parity |-> mchk_pulse)
	else $error("push parity without machine check");
a_check_op: assert property (mchk_pulse |-> mchk_op == act_op)
	else $error("machine check op differs from action op");
a_op_holds: assert property (!mchk_pulse |-> $stable(mchk_op))
	else $error("check op changed without a check");
endmodule
`default_nettype wire

// File: verification/core_req_model.sv
// Core pipeline request source for the policy block
`timescale 1ns/1ps
`default_nettype none
module core_req_model (
	// Clock
	input wire logic        clk_sys,
	// Request and lookup state
	output var logic        req_valid,
	output var logic [3:0]  req_op,
	output var logic        req_icache,
	output var logic [1:0]  selected_way,
	output var logic [35:0] look
);
initial begin
	req_valid = 1'b0;
	req_op = 4'h0;
	req_icache = 1'b0;
	selected_way = 2'h0;
	look = 36'h0;
end
// Lookup is scrambled after the strobe so stale state never looks live
task issue(input logic [3:0] o, input logic ic, input logic [1:0] s, input logic [35:0] st);
	begin
		@(posedge clk_sys);
		req_valid <= 1'b1;
		req_op <= o;
		req_icache <= ic;
		selected_way <= s;
		look <= st;
		@(posedge clk_sys);
		req_valid <= 1'b0;
		look <= ~st;
	end
endtask
endmodule
`default_nettype wire

// File: verification/testbench.sv
// Self-checking bench for the cache maintenance error policy
`timescale 1ns/1ps
`default_nettype none
`include "cache_maint_map.vh"
module testbench;
logic        clk_sys = 1'b0;
logic        reset = 1'b1;
logic        ce = 1'b1;
logic        ice = 1'b1;
logic        cacheable = 1'b1;
logic [1:0]  ea = 2'h0;
logic        req_valid, req_icache, act_valid, act_correct_cycle, act_nop;
logic        mchk_pulse, mchk_push_parity;
logic [3:0]  req_op, act_op, act_invalidate, act_writeback, mchk_op;
logic [3:0]  act_clear_lock, act_set_lock, act_zero;
logic [3:0]  last_op = 4'h0;
logic [1:0]  selected_way;
logic [35:0] look;
int          n_mismatch = 0;
int          cmp_count = 0;
always #10 clk_sys = ~clk_sys;
core_req_model u_core (.clk_sys(clk_sys), .req_valid(req_valid), .req_op(req_op),
	.req_icache(req_icache), .selected_way(selected_way), .look(look));
cache_maint_error_policy u_dut (.clk_sys(clk_sys), .reset(reset),
	.dcache_error_check_enable(ce), .icache_error_check_enable(ice),
	.dcache_error_action(ea), .icache_error_action(ea), .req_valid(req_valid),
	.req_op(req_op), .req_icache(req_icache), .req_cacheable(cacheable),
	.selected_way(selected_way), .way_valid(look[35:32]), .way_tag_match(look[31:28]),
	.way_tag_err(look[27:24]), .way_tag_unc(look[23:20]), .way_locked(look[19:16]),
	.way_lock_err(look[15:12]), .way_dirty(look[11:8]), .way_dirty_err(look[7:4]),
	.way_data_err(look[3:0]), .act_valid(act_valid), .act_op(act_op),
	.act_invalidate(act_invalidate), .act_writeback(act_writeback),
	.act_clear_lock(act_clear_lock), .act_set_lock(act_set_lock), .act_zero(act_zero),
	.act_correct_cycle(act_correct_cycle), .act_nop(act_nop),
	.mchk_pulse(mchk_pulse), .mchk_push_parity(mchk_push_parity), .mchk_op(mchk_op));
//////////////////////////////////////////////////
task stop_test;
	if (n_mismatch == 0 && cmp_count > 0)
		$display("Run complete: PASS");
	else
		$display("Run complete: FAIL");
	$finish;
endtask
task chk(input logic [31:0] seen, input logic [31:0] exp);
	cmp_count++;
	if (seen !== exp) begin
		n_mismatch++;
		$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
	end
endtask
task mode(input logic [1:0] a, input logic de, input logic ie, input logic c);
	@(posedge clk_sys);
	ea <= a;
	ce <= de;
	ice <= ie;
	cacheable <= c;
endtask
// Lookup digits: valid match tag_err unc locked lock_err dirty dirty_err data_err
// Result digits: {nop,correct,check,push}, clear_lock, set_lock, zero, invalidate, writeback
task run(input logic [3:0] o, input logic ic, input logic [1:0] s,
	input logic [35:0] st, input logic [23:0] exp);
	u_core.issue(o, ic, s, st);
	#1;
	if (exp[21])
		last_op = o;
	chk({act_nop, act_correct_cycle, mchk_pulse, mchk_push_parity, act_clear_lock,
		act_set_lock, act_zero, act_invalidate, act_writeback}, exp);
	chk({act_valid, act_op, mchk_op}, {1'b1, o, last_op});
endtask
initial begin
	repeat (20) @(posedge clk_sys);
	reset <= 1'b0;
	run(`CM_OP_REG_FLUSH, 0, 1, 36'h200000202, 24'h300002);
	run(`CM_OP_REG_FLINV, 0, 1, 36'h200000202, 24'h300002);
	run(`CM_OP_REG_FLINV, 0, 2, 36'h501105000, 24'h040040);
	run(`CM_OP_REG_FLUSH, 0, 3, 36'h808800800, 24'h200000);
	run(`CM_OP_REG_FLINV, 0, 3, 36'h808800000, 24'h080080);
	run(`CM_OP_REG_FLUSH, 0, 3, 36'h808800000, 24'h000000);
	run(`CM_OP_REG_INV, 0, 0, 36'h101100101, 24'h010010);
	run(`CM_OP_TOUCH, 0, 0, 36'h111100100, 24'h800000);
	run(`CM_OP_IBLK_INV, 1, 0, 36'h111100000, 24'h000010);
	run(`CM_OP_IBLK_INV, 1, 0, 36'h111110000, 24'h000000);
	run(`CM_OP_DBLK_INV, 0, 0, 36'h624400000, 24'h000020);
	run(`CM_OP_DBLK_INV, 0, 0, 36'h101100100, 24'h000000);
	run(`CM_OP_DBLK_STORE, 0, 0, 36'h110000101, 24'h300001);
	run(`CM_OP_DBLK_STORE, 0, 0, 36'h404400400, 24'h200000);
	run(`CM_OP_DBLK_FLUSH, 0, 0, 36'h110000100, 24'h000011);
	run(`CM_OP_DBLK_ZERO, 0, 0, 36'h404400400, 24'h200000);
	run(`CM_OP_DBLK_ZERO, 0, 0, 36'h110000000, 24'h000100);
	run(`CM_OP_LOCK_SET, 0, 0, 36'h202200000, 24'h200000);
	run(`CM_OP_LOCK_CLR, 0, 0, 36'h202220000, 24'h200000);
	run(`CM_OP_LOCK_CLR, 0, 0, 36'h110010000, 24'h010000);
	mode(2'h0, 1'b1, 1'b1, 1'b0);
	run(`CM_OP_DBLK_STORE, 0, 0, 36'h404400400, 24'h000000);
	mode(2'h1, 1'b1, 1'b1, 1'b1);
	run(`CM_OP_IBLK_INV, 1, 0, 36'h111100000, 24'h400010);
	run(`CM_OP_IBLK_INV, 1, 0, 36'h101110000, 24'h400000);
	run(`CM_OP_DBLK_INV, 0, 0, 36'h624400000, 24'h000060);
	run(`CM_OP_DBLK_FLUSH, 0, 0, 36'h202220000, 24'h200000);
	run(`CM_OP_DBLK_FLUSH, 0, 0, 36'h202200000, 24'h000020);
	run(`CM_OP_LOCK_SET, 0, 0, 36'h624400000, 24'h002040);
	run(`CM_OP_LOCK_CLR, 0, 0, 36'h202220000, 24'h200020);
	mode(2'h1, 1'b0, 1'b1, 1'b1);
	run(`CM_OP_DBLK_STORE, 0, 0, 36'h404400400, 24'h000000);
	run(`CM_OP_IBLK_INV, 1, 0, 36'h111100000, 24'h400010);
	mode(2'h1, 1'b1, 1'b0, 1'b1);
	run(`CM_OP_IBLK_INV, 1, 0, 36'h111100000, 24'h000010);
	stop_test;
end
// Whole run is about 100 cycles; the limit leaves ample margin
initial begin
	#100000;
	n_mismatch++;
	stop_test;
end
endmodule
bind cache_maint_error_policy cache_maint_error_policy_asserts u_chk (.clk_sys, .reset,
	.dcache_error_check_enable, .icache_error_check_enable, .req_valid, .req_op,
	.req_icache, .selected_way, .act_valid, .act_op, .act_invalidate, .mchk_pulse,
	.mchk_push_parity, .mchk_op);
`default_nettype wire
